// file: uart_flow_trigger_regs.vh
`ifndef UART_FLOW_TRIGGER_REGS_VH
`define UART_FLOW_TRIGGER_REGS_VH
// Register addresses on the 3-bit host bus
`define ADR_0         3'h0
`define ADR_1         3'h1
`define ADR_2         3'h2
`define ADR_3         3'h3
`define ADR_4         3'h4
`define ADR_6         3'h6
`define ADR_7         3'h7
// Line-control value that opens the enhanced bank
`define LCR_KEY       8'hBF
`define LCR_DLAB      7
// Enhanced feature control bits
`define EFC_SWF_HI    3
`define EFC_ENH       4
`define EFC_SPC       5
`define EFC_RTS       6
`define EFC_CTS       7
// Interrupt enable bits
`define IEN_TXH       1
`define IEN_SLEEP     4
// Modem control bits
`define MOD_RTS       1
`define MOD_RDY       2
`define MOD_LOOP      4
`define MOD_ALT       6
`define FCTL_EN       0
// Bits writable only under the enhanced gate
`define IEN_GATED     8'hF0
`define FCTL_GATED    8'h30
`define MOD_GATED     8'hE0
`define RST_BYTE      8'h00
`define RST_BIT       1'b0
`define RST_HIGH      1'b1
`define FIFO_DEPTH    7'h40
`define SYNC_IDLE     17'h1FFFF
// Register selector codes
`define SEL_NONE      4'h0
`define SEL_DIV_LO    4'h1
`define SEL_DIV_HI    4'h2
`define SEL_XMIT      4'h3
`define SEL_IEN       4'h4
`define SEL_EFC       4'h5
`define SEL_IDENT     4'h6
`define SEL_FIFO_CTL  4'h7
`define SEL_LINE      4'h8
`define SEL_MODEM     4'h9
`define SEL_THRESH    4'hA
`define SEL_TRIG      4'hB
`define SEL_STOP2     4'hC
`define SEL_READY     4'hD
`endif

// file: uart_flow_trigger_config.v
// Contract
// R1: Low nibble selects software flow control mode
// R2: Enhanced gate blocks writes to upper control bits
// R3: Special character match sets identification bit four
// R4: Auto RTS halts/resumes on threshold nibbles
// R5: Auto CTS high stops the transmitter
// R6: Two divisor bytes form sixteen-bit divisor
// R7: Divisor writes refused while sleep enabled
// R8: Threshold nibbles encode levels in steps four
// R9: Threshold writes need enhanced gate and alternate
// R10: Host keeps halt above resume, set first
// R11: Trigger nibbles: transmit spaces, receive characters
// R12: Trigger writes need enhanced gate and alternate
// R13: Zero trigger nibble falls back to control
// R14: Ready bits 0,1 report transmit spaces
// R15: Ready bits 4,5 report receive data/timeout
// R16: Shared read-only ready register at seven
// R17: Re-enabling transmit interrupt raises nothing new
// R18: Modem bit six opens threshold/trigger registers
// R19: Modem bit two presents the ready register
// R20: Interrupt-enable bit four selects sleep mode
// R21: Effective trigger from nibble or fallback input
`timescale 1ns/100ps
`include "uart_flow_trigger_regs.vh"
module uart_flow_trigger_config (
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  input  wire [1:0]  chan_sel_n_i,
  input  wire        rd_n_i,
  input  wire        wr_n_i,
  input  wire [2:0]  addr_i,
  input  wire [7:0]  data_i,
  output wire [7:0]  data_o,
  output wire        data_oe_n_o,
  input  wire [1:0]  cts_n_i,
  input  wire [13:0] rx_level_i,
  input  wire [13:0] tx_level_i,
  input  wire [13:0] fallback_rx_trig_i,
  input  wire [13:0] fallback_tx_trig_i,
  input  wire [1:0]  rx_timeout_i,
  input  wire [1:0]  rx_char_valid_i,
  input  wire [15:0] rx_char_i,
  output wire [1:0]  rts_n_o,
  output wire [1:0]  tx_halt_o,
  output wire [1:0]  special_char_o,
  output wire [1:0]  tx_hold_irq_o,
  output wire [7:0]  sw_flow_mode_o,
  output wire [31:0] divisor_o,
  output wire [15:0] interrupt_enable_o,
  output wire [15:0] modem_control_o,
  output wire [15:0] fifo_control_o
);

  // Pins are asynchronous to sys_clk_i: two flops before use
  reg  [16:0] pin_s1_r;
  reg  [16:0] pin_s2_r;
  reg         rd_n_d_r;
  reg         wr_n_d_r;
  reg  [7:0]  data_r;
  reg         oe_n_r;
  wire [1:0]  cs_s;
  wire        rd_s;
  wire        wr_s;
  wire [2:0]  a_s;
  wire [7:0]  d_s;
  wire [1:0]  cts_s;
  wire        rd_ev;
  wire        wr_ev;
  wire [1:0]  tx_rdy_w;
  wire [1:0]  rx_rdy_w;
  wire [7:0]  ready_byte;
  wire [15:0] rd_all;

  assign cs_s  = pin_s2_r[1:0];
  assign rd_s  = pin_s2_r[2];
  assign wr_s  = pin_s2_r[3];
  assign a_s   = pin_s2_r[6:4];
  assign d_s   = pin_s2_r[14:7];
  assign cts_s = pin_s2_r[16:15];
  assign rd_ev = rd_n_d_r & ~rd_s;
  // Write takes effect on the trailing edge, when data is known settled
  assign wr_ev = ~wr_n_d_r & wr_s;
  assign ready_byte = {2'b00, rx_rdy_w, 2'b00, tx_rdy_w}; // R14 R15 R16

  function [3:0] reg_sel;
    input [2:0] a;
    input [7:0] lcr;
    input [7:0] modem;
    input [7:0] efc;
    input       is_rd;
    reg         key;
    reg         alt;
    begin
      key = (lcr == `LCR_KEY);
      alt = efc[`EFC_ENH] & modem[`MOD_ALT]; // R9 R12 R18
      case (a)
        `ADR_0: reg_sel = lcr[`LCR_DLAB] ? `SEL_DIV_LO : `SEL_XMIT;
        `ADR_1: reg_sel = lcr[`LCR_DLAB] ? `SEL_DIV_HI : `SEL_IEN;
        `ADR_2: reg_sel = key ? `SEL_EFC : (is_rd ? `SEL_IDENT : `SEL_FIFO_CTL);
        `ADR_3: reg_sel = `SEL_LINE;
        `ADR_4: reg_sel = key ? `SEL_NONE : `SEL_MODEM;
        `ADR_6: reg_sel = (!key && alt) ? `SEL_THRESH : `SEL_NONE;
        `ADR_7:
        begin
          if (key)
            reg_sel = `SEL_STOP2;
          else if (is_rd && modem[`MOD_RDY] && !modem[`MOD_LOOP]) // R16 R19
            reg_sel = `SEL_READY;
          else if (alt)
            reg_sel = `SEL_TRIG;
          else
            reg_sel = `SEL_NONE;
        end
        default: reg_sel = `SEL_NONE;
      endcase
    end
  endfunction

  // Gated bits keep their old value unless the enhanced gate is open
  function [7:0] gated_wr;
    input [7:0] old_v;
    input [7:0] new_v;
    input [7:0] mask;
    input       en;
    begin
      gated_wr = en ? new_v : ((new_v & ~mask) | (old_v & mask)); // R2
    end
  endfunction

  function [6:0] eff_trig;
    input [3:0] nib;
    input [6:0] fallback;
    begin
      eff_trig = (nib != 4'h0) ? {1'b0, nib, 2'b00} : fallback; // R11 R13 R21
    end
  endfunction

  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_s1_r <= `SYNC_IDLE;
      pin_s2_r <= `SYNC_IDLE;
      rd_n_d_r <= `RST_HIGH;
      wr_n_d_r <= `RST_HIGH;
    end
    else
    begin
      pin_s1_r <= {cts_n_i, data_i, addr_i, wr_n_i, rd_n_i, chan_sel_n_i};
      pin_s2_r <= pin_s1_r;
      rd_n_d_r <= rd_s;
      wr_n_d_r <= wr_s;
    end
  end

  // Read data is latched at the leading edge of the strobe and held
  always @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      data_r <= `RST_BYTE;
      oe_n_r <= `RST_HIGH;
    end
    else if (rd_ev && (cs_s != 2'b11))
    begin
      data_r <= cs_s[0] ? rd_all[15:8] : rd_all[7:0];
      oe_n_r <= `RST_BIT;
    end
    else if (rd_s || (cs_s == 2'b11))
      oe_n_r <= `RST_HIGH;
  end

  assign data_o      = data_r;
  assign data_oe_n_o = oe_n_r;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : chan
      reg  [7:0] efc_r;
      reg  [7:0] div_lo_r;
      reg  [7:0] div_hi_r;
      reg  [7:0] ien_r;
      reg  [7:0] fctl_r;
      reg  [7:0] line_r;
      reg  [7:0] modem_r;
      reg  [7:0] thresh_r;
      reg  [7:0] trig_r;
      reg  [7:0] stop2_r;
      reg        spc_r;
      reg        txh_pend_r;
      reg        txh_irq_r;
      reg        rts_n_r;
      reg        halt_r;
      reg        tx_rdy_r;
      reg        rx_rdy_r;
      reg  [7:0] rd_mux;
      wire [3:0] sel_wr;
      wire [3:0] sel_rd;
      wire       wr;
      wire       rd;
      wire [6:0] tx_trig;
      wire [6:0] rx_trig;
      wire [6:0] rx_lvl;
      wire [6:0] tx_space;
      wire       tx_rdy_nxt;
      wire       rx_rdy_nxt;
      wire       spc_hit;

      assign sel_wr   = reg_sel(a_s, line_r, modem_r, efc_r, 1'b0);
      assign sel_rd   = reg_sel(a_s, line_r, modem_r, efc_r, 1'b1);
      assign wr       = wr_ev & ~cs_s[g];
      assign rd       = rd_ev & ~cs_s[g];
      assign tx_trig  = eff_trig(trig_r[3:0], fallback_tx_trig_i[7*g +: 7]);
      assign rx_trig  = eff_trig(trig_r[7:4], fallback_rx_trig_i[7*g +: 7]);
      assign rx_lvl   = rx_level_i[7*g +: 7];
      assign tx_space = `FIFO_DEPTH - tx_level_i[7*g +: 7];
      assign tx_rdy_nxt = (tx_space >= tx_trig); // R14
      assign rx_rdy_nxt = (rx_lvl > rx_trig) | rx_timeout_i[g]; // R15
      assign spc_hit  = efc_r[`EFC_SPC] & rx_char_valid_i[g] & (rx_char_i[8*g +: 8] == stop2_r); // R3

      always @(posedge sys_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          efc_r    <= `RST_BYTE;
          div_lo_r <= `RST_BYTE;
          div_hi_r <= `RST_BYTE;
          ien_r    <= `RST_BYTE;
          fctl_r   <= `RST_BYTE;
          line_r   <= `RST_BYTE;
          modem_r  <= `RST_BYTE;
          thresh_r <= `RST_BYTE;
          trig_r   <= `RST_BYTE;
          stop2_r  <= `RST_BYTE;
        end
        else if (wr)
        begin
          case (sel_wr)
            `SEL_DIV_LO: if (!ien_r[`IEN_SLEEP]) div_lo_r <= d_s; // R7
            `SEL_DIV_HI: if (!ien_r[`IEN_SLEEP]) div_hi_r <= d_s; // R7
            `SEL_IEN:      ien_r <= gated_wr(ien_r, d_s, `IEN_GATED, efc_r[`EFC_ENH]); // R2 R20
            `SEL_FIFO_CTL: fctl_r <= gated_wr(fctl_r, d_s, `FCTL_GATED, efc_r[`EFC_ENH]); // R2
            `SEL_MODEM:    modem_r <= gated_wr(modem_r, d_s, `MOD_GATED, efc_r[`EFC_ENH]); // R2
            `SEL_EFC:    efc_r <= d_s; // R1
            `SEL_LINE:   line_r <= d_s;
            `SEL_THRESH: thresh_r <= d_s; // R8 R9
            `SEL_TRIG:   trig_r <= d_s; // R12
            `SEL_STOP2:  stop2_r <= d_s;
            default: ;
          endcase
        end
      end

      // Hardware-set flags: a set in the clearing cycle wins
      always @(posedge sys_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          spc_r      <= `RST_BIT;
          txh_pend_r <= `RST_BIT;
          txh_irq_r  <= `RST_BIT;
          rts_n_r    <= `RST_HIGH;
          halt_r     <= `RST_BIT;
          // Starts high like an empty FIFO, so reset leaves no false rising edge
          tx_rdy_r   <= `RST_HIGH;
          rx_rdy_r   <= `RST_BIT;
        end
        else
        begin
          spc_r <= spc_hit | (spc_r & ~(rd && (sel_rd == `SEL_IDENT))); // R3
          // Pending is raised only by the space level crossing, never by the enable write
          txh_pend_r <= (tx_rdy_nxt & ~tx_rdy_r) |
                        (txh_pend_r & ~(wr && (sel_wr == `SEL_XMIT))); // R17
          txh_irq_r  <= ien_r[`IEN_TXH] & txh_pend_r; // R17
          tx_rdy_r   <= tx_rdy_nxt; // R14
          rx_rdy_r   <= rx_rdy_nxt; // R15
          halt_r     <= efc_r[`EFC_CTS] & cts_s[g]; // R5
          // No ordering check on the nibbles: host must keep halt above resume
          if (efc_r[`EFC_RTS])
          begin
            if (rx_lvl >= {1'b0, thresh_r[3:0], 2'b00})
              rts_n_r <= `RST_HIGH; // R4 R8 R10
            else if (rx_lvl <= {1'b0, thresh_r[7:4], 2'b00})
              rts_n_r <= `RST_BIT; // R4 R8
          end
          else
            rts_n_r <= ~modem_r[`MOD_RTS];
        end
      end

      always @*
      begin
        case (sel_rd)
          `SEL_DIV_LO: rd_mux = div_lo_r;
          `SEL_DIV_HI: rd_mux = div_hi_r;
          `SEL_IEN:    rd_mux = ien_r;
          `SEL_IDENT:  rd_mux = {fctl_r[`FCTL_EN], fctl_r[`FCTL_EN], 1'b0, spc_r, 3'b000, ~spc_r}; // R3
          `SEL_EFC:    rd_mux = efc_r;
          `SEL_LINE:   rd_mux = line_r;
          `SEL_MODEM:  rd_mux = modem_r;
          `SEL_THRESH: rd_mux = thresh_r;
          `SEL_TRIG:   rd_mux = trig_r;
          `SEL_STOP2:  rd_mux = stop2_r;
          `SEL_READY:  rd_mux = ready_byte; // R16
          default:     rd_mux = `RST_BYTE;
        endcase
      end

      assign rd_all[8*g +: 8]              = rd_mux;
      assign tx_rdy_w[g]                   = tx_rdy_r;
      assign rx_rdy_w[g]                   = rx_rdy_r;
      assign rts_n_o[g]                    = rts_n_r;
      assign tx_halt_o[g]                  = halt_r;
      assign special_char_o[g]             = spc_r;
      assign tx_hold_irq_o[g]              = txh_irq_r;
      assign sw_flow_mode_o[4*g +: 4]      = efc_r[`EFC_SWF_HI:0]; // R1
      assign divisor_o[16*g +: 16]         = {div_hi_r, div_lo_r}; // R6
      assign interrupt_enable_o[8*g +: 8]  = ien_r;
      assign modem_control_o[8*g +: 8]     = modem_r;
      assign fifo_control_o[8*g +: 8]      = fctl_r;
    end
  endgenerate

endmodule // uart_flow_trigger_config

// file: host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
  input  wire       sys_clk_i,
  output reg  [1:0] chan_sel_n_o,
  output reg        rd_n_o,
  output reg        wr_n_o,
  output reg  [2:0] addr_o,
  output reg  [7:0] data_o,
  input  wire [7:0] data_i
);
  initial
  begin
    chan_sel_n_o = 2'b11;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 3'h0;
    data_o = 8'h00;
  end
  // Both selects low so every write lands in both channels
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge sys_clk_i) #1;
      chan_sel_n_o = 2'b00;
      addr_o = a;
      data_o = d;
      wr_n_o = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      #1 wr_n_o = 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1 chan_sel_n_o = 2'b11;
      // Released bus shows the inverse so stale data cannot pass
      data_o = ~d;
      repeat (3) @(posedge sys_clk_i);
      #1;
    end
  endtask
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge sys_clk_i) #1;
      chan_sel_n_o = 2'b10;
      addr_o = a;
      rd_n_o = 1'b0;
      repeat (6) @(posedge sys_clk_i);
      d = data_i;
      #1 rd_n_o = 1'b1;
      chan_sel_n_o = 2'b11;
      repeat (5) @(posedge sys_clk_i);
      #1;
    end
  endtask
endmodule // host_bus_model

// file: cfg_chk.sv
`timescale 1ns/100ps
module cfg_chk (
  input wire        sys_clk_i,
  input wire        rstn_i,
  input wire [1:0]  chan_sel_n_i,
  input wire        rd_n_i,
  input wire        wr_n_i,
  input wire        data_oe_n_o,
  input wire [1:0]  cts_n_i,
  input wire [1:0]  rx_char_valid_i,
  input wire [1:0]  tx_halt_o,
  input wire [1:0]  special_char_o,
  input wire [1:0]  tx_hold_irq_o,
  input wire [7:0]  sw_flow_mode_o,
  input wire [31:0] divisor_o,
  input wire [15:0] interrupt_enable_o
);
  reg [3:0] wr_age_r;
  // Cycles since the write strobe was last low, saturating
  always @(posedge sys_clk_i or negedge rstn_i)
    if (!rstn_i)
      wr_age_r <= 4'hF;
    else if (!wr_n_i)
      wr_age_r <= 4'h0;
    else if (wr_age_r != 4'hF)
      wr_age_r <= wr_age_r + 4'h1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  div_sleep_a: assert property ($changed(divisor_o) |-> !$past(interrupt_enable_o[4] | interrupt_enable_o[12]))
    else $error("divisor changed in sleep mode");
  div_write_a: assert property ($changed(divisor_o) |-> wr_age_r < 4'h7)
    else $error("divisor changed without write");
  flow_write_a: assert property ($changed(sw_flow_mode_o) |-> wr_age_r < 4'h7)
    else $error("flow mode changed without write");
  ien_write_a: assert property ($changed(interrupt_enable_o) |-> wr_age_r < 4'h7)
    else $error("interrupt enable changed without write");
  cts_idle_a: assert property (!cts_n_i[0] [*5] |-> !tx_halt_o[0])
    else $error("halt with clear to send low");
  txh_enable_a: assert property (tx_hold_irq_o[0] |-> $past(interrupt_enable_o[1]))
    else $error("transmit interrupt while disabled");
  spc_cause_a: assert property ($rose(special_char_o[0]) |-> $past(rx_char_valid_i[0], 1) | $past(rx_char_valid_i[0], 2))
    else $error("special flag without character");
  oe_release_a: assert property ($rose(rd_n_i) |-> ##[1:5] data_oe_n_o)
    else $error("bus not released after read");
  oe_drive_a: assert property ($fell(rd_n_i) && chan_sel_n_i != 2'b11 |-> ##[2:5] !data_oe_n_o)
    else $error("bus not driven on read");
endmodule // cfg_chk

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg         sys_clk;
  reg         rstn;
  reg  [1:0]  cts;
  reg  [13:0] rxl;
  reg  [13:0] txl;
  reg  [13:0] fbr;
  reg  [13:0] fbt;
  reg  [1:0]  tmo;
  reg  [1:0]  vld;
  reg  [15:0] ch;
  wire [1:0]  sel_n;
  wire        rd_n;
  wire        wr_n;
  wire        oe_n;
  wire [2:0]  adr;
  wire [7:0]  hd;
  wire [7:0]  q;
  wire [7:0]  bus = oe_n ? hd : q;
  integer     n_mismatch = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  host_bus_model host (.sys_clk_i(sys_clk), .chan_sel_n_o(sel_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(adr),
    .data_o(hd), .data_i(bus));
  uart_flow_trigger_config dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .chan_sel_n_i(sel_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .addr_i(adr), .data_i(bus), .data_o(q), .data_oe_n_o(oe_n), .cts_n_i(cts), .rx_level_i(rxl),
    .tx_level_i(txl), .fallback_rx_trig_i(fbr), .fallback_tx_trig_i(fbt), .rx_timeout_i(tmo),
    .rx_char_valid_i(vld), .rx_char_i(ch), .rts_n_o(), .tx_halt_o(), .special_char_o(), .tx_hold_irq_o(),
    .sw_flow_mode_o(), .divisor_o(), .interrupt_enable_o(), .modem_control_o(), .fifo_control_o());
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task close_out;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [63:0] got, input [63:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task rchk(input [2:0] a, input [7:0] e);
    reg [7:0] v;
    begin
      host.rd(a, v);
      chk("read", v, e);
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  initial
  begin
    rstn = 1'b0;
    cts = 2'b00;
    {rxl, txl, fbr, fbt, tmo, vld, ch} = 0;
    step(8);
    rstn = 1'b1;
    step(3);
    chk("reset", {dut.rts_n_o, oe_n, dut.divisor_o}, {2'b11, 1'b1, 32'h0});
    host.wr(3'h3, 8'h00);
    host.wr(3'h1, 8'hF3);
    host.wr(3'h2, 8'h31);
    host.wr(3'h4, 8'hE0);
    chk("gate", {dut.interrupt_enable_o[7:0], dut.fifo_control_o[7:0], dut.modem_control_o[7:0]}, 24'h030100);
    chk("txhreset", dut.tx_hold_irq_o, 2'b00);
    host.wr(3'h3, 8'hBF);
    host.wr(3'h2, 8'h1A);
    host.wr(3'h3, 8'h00);
    chk("flow", dut.sw_flow_mode_o, 8'hAA);
    host.wr(3'h1, 8'hF0);
    chk("ien", dut.interrupt_enable_o, 16'hF0F0);
    host.wr(3'h3, 8'h80);
    host.wr(3'h0, 8'h55);
    chk("sleepdiv", dut.divisor_o, 32'h0);
    host.wr(3'h3, 8'h00);
    host.wr(3'h1, 8'h00);
    host.wr(3'h3, 8'h80);
    host.wr(3'h0, 8'h34);
    host.wr(3'h1, 8'h12);
    chk("divisor", dut.divisor_o, 32'h12341234);
    host.wr(3'h3, 8'h00);
    host.wr(3'h4, 8'h40);
    host.wr(3'h6, 8'h28);
    host.wr(3'h7, 8'h21);
    rchk(3'h6, 8'h28);
    rchk(3'h7, 8'h21);
    host.wr(3'h4, 8'h00);
    host.wr(3'h6, 8'h77);
    host.wr(3'h4, 8'h40);
    rchk(3'h6, 8'h28);
    rxl = {7'd8, 7'd9};
    txl = {7'd61, 7'd60};
    host.wr(3'h4, 8'h44);
    rchk(3'h7, 8'h11);
    tmo = 2'b10;
    rchk(3'h7, 8'h31);
    tmo = 2'b00;
    host.wr(3'h4, 8'h40);
    host.wr(3'h7, 8'h00);
    fbt = {7'd3, 7'd5};
    fbr = {7'd7, 7'd10};
    host.wr(3'h4, 8'h44);
    rchk(3'h7, 8'h22);
    host.wr(3'h4, 8'h14);
    rchk(3'h7, 8'h00);
    host.wr(3'h4, 8'h00);
    rchk(3'h7, 8'h00);
    host.wr(3'h3, 8'hBF);
    host.wr(3'h2, 8'h50);
    host.wr(3'h3, 8'h00);
    // Halt at 32, resume at 8, hold in between
    for (i = 0; i < 5; i = i + 1)
    begin
      rxl[6:0] = {7'd8, 7'd9, 7'd32, 7'd31, 7'd5} >> (7 * i);
      step(4);
      chk("rts", dut.rts_n_o[0], (5'b01100 >> i) & 5'h01);
    end
    cts = 2'b01;
    step(5);
    chk("nohalt", dut.tx_halt_o, 2'b00);
    host.wr(3'h3, 8'hBF);
    host.wr(3'h7, 8'h13);
    host.wr(3'h2, 8'hF0);
    host.wr(3'h3, 8'h00);
    chk("halt", dut.tx_halt_o, 2'b01);
    cts = 2'b00;
    step(5);
    chk("resume", dut.tx_halt_o, 2'b00);
    for (i = 0; i < 2; i = i + 1)
    begin
      ch[7:0] = 8'h12 + i[7:0];
      vld = 2'b01;
      step(1);
      vld = 2'b00;
      step(3);
      chk("special", dut.special_char_o, i);
    end
    rchk(3'h2, 8'hD0);
    chk("spcclr", dut.special_char_o, 2'b00);
    txl[6:0] = 7'd64;
    host.wr(3'h0, 8'h00);
    host.wr(3'h1, 8'h02);
    step(3);
    chk("txhquiet", dut.tx_hold_irq_o[0], 1'b0);
    txl[6:0] = 7'd0;
    step(4);
    chk("txhirq", dut.tx_hold_irq_o[0], 1'b1);
    close_out;
  end
endmodule // tb_top
bind uart_flow_trigger_config cfg_chk chk_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .chan_sel_n_i(chan_sel_n_i),
  .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .data_oe_n_o(data_oe_n_o), .cts_n_i(cts_n_i), .rx_char_valid_i(rx_char_valid_i),
  .tx_halt_o(tx_halt_o), .special_char_o(special_char_o), .tx_hold_irq_o(tx_hold_irq_o), .sw_flow_mode_o(sw_flow_mode_o),
  .divisor_o(divisor_o), .interrupt_enable_o(interrupt_enable_o));
